// >>> src/lbis_map.svh
/*
 Offsets, field positions, reset values and timing counts
 of the logic block input unit.
 Assumes a 100 MHz system clock and byte addresses on APB.
*/
`ifndef LBIS_MAP_SVH
`define LBIS_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LBIS_A_LOGIC  8'h00
`define LBIS_A_SFIN   8'h04
`define LBIS_A_SFCFG  8'h08
`define LBIS_A_STAT   8'h0C
`define LBIS_A_COUNT  8'h10
`define LBIS_A_ELAP   8'h14
`define LBIS_A_RTC    8'h18
`define LBIS_A_AIN    8'h1C
`define LBIS_A_GAIN   8'h20
`define LBIS_A_OFFS   8'h24
`define LBIS_A_SCALED 8'h28
`define LBIS_A_MSGG   8'h2C
`define LBIS_A_HOURS  8'h30
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LBIS_F_S      0
`define LBIS_F_R      1
`define LBIS_F_TRG    2
`define LBIS_F_CNT    3
`define LBIS_F_DIR    4
`define LBIS_F_EN     5
`define LBIS_F_INV    6
`define LBIS_F_RAL    7
`define LBIS_F_LAP    8
`define LBIS_F_CONN   16
`define LBIS_F_RET    2
`define LBIS_F_PROT   3
`define LBIS_F_PROG   4
`define LBIS_F_MPROT  5
`define LBIS_F_TVAL   16
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LBIS_RST_GAIN 11'sh064
// ----------------------------------------
// Timing and scaling
// ----------------------------------------
`define LBIS_CLK_MHZ    100
`define LBIS_TICK_MS    10
`define LBIS_TICK_CYC   (`LBIS_TICK_MS * 1000 * `LBIS_CLK_MHZ)
`define LBIS_SEC_MS     1000
`define LBIS_SEC_TICKS  (`LBIS_SEC_MS / `LBIS_TICK_MS)
`define LBIS_MIN_TICKS  (60 * `LBIS_SEC_TICKS)
`define LBIS_BKUP_DAYS  20
`define LBIS_BKUP_SEC   (`LBIS_BKUP_DAYS * 86400)
`define LBIS_AIN_MAX    1000
`define LBIS_GAIN_LIM   1000
`define LBIS_OFFS_LIM   10000
`define LBIS_GAIN_DIV   100
`endif

// >>> src/lbis_pkg.sv
/*
 Types of the logic block input unit.
 Assumes lbis_map.svh for all numbers.
*/
`default_nettype none
package lbis_pkg;
    typedef enum logic [1:0] {TB_SEC, TB_MIN, TB_HR, TB_10MS} lbis_tb_e;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lbis_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lbis_apb_rsp_s;
    typedef struct packed {
        logic [31:0]        prdata;
        logic [4:0]         lg;
        logic [8:0]         sfv;
        logic [8:0]         sfc;
        lbis_tb_e           tb;
        logic               ret;
        logic               prot;
        logic               prog;
        logic               mprot;
        logic [15:0]        tval;
        logic               xor_q;
        logic               not_q;
        logic               sf_q;
        logic               q_out;
        logic               trg_d;
        logic               cnt_d;
        logic [15:0]        count;
        logic [31:0]        tleft;
        logic               trun;
        logic [31:0]        elapsed;
        logic [31:0]        swdiv;
        logic [31:0]        tick;
        logic [6:0]         subsec;
        logic [31:0]        rtc;
        logic [31:0]        rtc_save;
        logic [31:0]        outage;
        logic               bk_exp;
        logic [31:0]        hours;
        logic [2:0]         pf_s;
        logic [2:0]         pps_s;
        logic               pf_lvl;
        logic               pps_lvl;
        logic [9:0]         ain;
        logic signed [10:0] gain;
        logic signed [14:0] offs;
        logic signed [31:0] scaled;
    } lbis_st_s;
endpackage
`default_nettype wire

// >>> src/lbis_top.sv
/*
 Logic block input unit: XOR and NOT gates, one special
 function with its control inputs, timer, counter and
 stopwatch, real-time clock with backup, retention,
 parameter protection and analog scaling, on APB.
 Assumes an ADC on CLK_SYS giving 10 mV steps, and
 asynchronous POWER_FAIL and REF_PPS pins.
*/
`include "lbis_map.svh"
`default_nettype none
module lbis_top #(
    parameter int TICK_CYC = `LBIS_TICK_CYC,
    parameter int BKUP_SEC = `LBIS_BKUP_SEC
) (
    input  wire logic                   CLK_SYS,
    input  wire logic                   SRST,
    input  wire lbis_pkg::lbis_apb_req_s APB_REQ,
    output lbis_pkg::lbis_apb_rsp_s     APB_RSP,
    input  wire logic [11:0]            SENSOR_VOLTAGE_IN,
    input  wire logic                   POWER_FAIL,
    input  wire logic                   REF_PPS,
    output logic                        XOR_Q,
    output logic                        NOT_Q,
    output logic                        SF_Q
);
    import lbis_pkg::*;

    lbis_st_s   st;
    lbis_st_s   nx;
    logic [8:0] v;
    logic       acc;
    logic       hit;
    logic       ed;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] unit_ticks(lbis_tb_e tb);
        case (tb)
            TB_MIN:  return 32'(`LBIS_SEC_TICKS);
            TB_HR:   return 32'(`LBIS_MIN_TICKS);
            default: return 32'h1;
        endcase
    endfunction

    function automatic logic [31:0] t_ticks(lbis_tb_e tb, logic [15:0] t);
        logic [31:0] mul;
        mul = (tb == TB_MIN || tb == TB_HR) ? 32'h3C : 32'(`LBIS_SEC_TICKS);
        return ({24'h0, t[15:8]} * mul + {24'h0, t[7:0]}) * unit_ticks(tb);
    endfunction

    function automatic logic signed [15:0] clamp(logic signed [31:0] x, int lim);
        if (x > lim) begin
            return 16'(lim);
        end
        if (x < -lim) begin
            return 16'(-lim);
        end
        return x[15:0];
    endfunction

    // Shift of the range after gain; divide truncates toward zero
    function automatic logic signed [31:0] scale(logic [9:0] a,
                                                 logic signed [10:0] g,
                                                 logic signed [14:0] o);
        logic signed [31:0] p;
        p = $signed({22'h0, a}) * 32'(g);
        p = p / 32'(`LBIS_GAIN_DIV);
        return p + 32'(o);
    endfunction

    assign v   = st.sfv & st.sfc;
    assign acc = APB_REQ.psel & APB_REQ.penable;
    assign hit = (APB_REQ.paddr[1:0] == 2'h0) && (APB_REQ.paddr <= `LBIS_A_HOURS);
    assign ed  = !st.prot | st.prog;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic pf_up;
        logic pf_dn;
        logic pps_up;
        logic run;
        logic tk;
        logic sec;
        logic trg_up;
        logic cnt_up;
        logic [31:0] rd;
        pf_up  = 1'b0;
        pf_dn  = 1'b0;
        pps_up = 1'b0;
        run    = 1'b0;
        tk     = 1'b0;
        sec    = 1'b0;
        trg_up = 1'b0;
        cnt_up = 1'b0;
        rd     = 32'h0;
        nx     = st;

        // Pins: a change counts once second and third flop agree
        nx.pf_s  = {st.pf_s[1:0], POWER_FAIL};
        nx.pps_s = {st.pps_s[1:0], REF_PPS};
        nx.pf_lvl  = (st.pf_s[2] == st.pf_s[1]) ? st.pf_s[2] : st.pf_lvl;
        nx.pps_lvl = (st.pps_s[2] == st.pps_s[1]) ? st.pps_s[2] : st.pps_lvl;
        pf_up  = nx.pf_lvl & !st.pf_lvl;
        pf_dn  = !nx.pf_lvl & st.pf_lvl;
        pps_up = nx.pps_lvl & !st.pps_lvl;
        run    = !st.pf_lvl;

        // Base tick and clock seconds
        tk = (st.tick == 32'(TICK_CYC - 1));
        nx.tick = tk ? 32'h0 : st.tick + 32'h1;
        if (tk) begin
            if (st.subsec == 7'(`LBIS_SEC_TICKS - 1)) begin
                sec = 1'b1;
                nx.subsec = 7'h0;
            end else begin
                nx.subsec = st.subsec + 7'h1;
            end
        end
        // Late second is made up, early one re-aligned
        if (pps_up) begin
            sec = (st.subsec >= 7'(`LBIS_SEC_TICKS / 2));
            nx.subsec = 7'h0;
        end
        if (sec && (run || !st.bk_exp)) begin
            nx.rtc = st.rtc + 32'h1;
        end

        // Backup span of the clock
        if (!run && sec && !st.bk_exp) begin
            nx.outage = st.outage + 32'h1;
            if (st.outage >= 32'(BKUP_SEC - 1)) begin
                nx.bk_exp = 1'b1;
            end
        end
        if (pf_up) begin
            nx.rtc_save = st.rtc;
            nx.outage   = 32'h0;
            nx.bk_exp   = 1'b0;
        end
        if (pf_dn && st.bk_exp) begin
            nx.rtc = st.rtc_save;
        end
        if (run && sec && st.sf_q) begin
            nx.hours = st.hours + 32'h1;
        end

        // Special function
        nx.trg_d = v[`LBIS_F_TRG];
        nx.cnt_d = v[`LBIS_F_CNT];
        trg_up = v[`LBIS_F_TRG] & !st.trg_d;
        cnt_up = v[`LBIS_F_CNT] & !st.cnt_d;
        if (run) begin
            if (v[`LBIS_F_RAL]) begin
                nx.sf_q    = 1'b0;
                nx.count   = 16'h0;
                nx.tleft   = 32'h0;
                nx.trun    = 1'b0;
                nx.elapsed = 32'h0;
                nx.swdiv   = 32'h0;
            end else if (v[`LBIS_F_R]) begin
                nx.sf_q  = 1'b0;
                nx.trun  = 1'b0;
                nx.tleft = 32'h0;
            end else if (v[`LBIS_F_EN]) begin
                if (v[`LBIS_F_S]) begin
                    nx.sf_q = 1'b1;
                end
                if (trg_up) begin
                    nx.trun  = 1'b1;
                    nx.tleft = t_ticks(st.tb, st.tval);
                end else if (st.trun && tk) begin
                    if (st.tleft <= 32'h1) begin
                        nx.trun = 1'b0;
                        nx.sf_q = 1'b1;
                    end else begin
                        nx.tleft = st.tleft - 32'h1;
                    end
                end
                if (cnt_up) begin
                    nx.count = v[`LBIS_F_DIR] ? st.count - 16'h1 : st.count + 16'h1;
                end
                if (tk && !v[`LBIS_F_LAP]) begin
                    if (st.swdiv >= unit_ticks(st.tb) - 32'h1) begin
                        nx.swdiv   = 32'h0;
                        nx.elapsed = st.elapsed + 32'h1;
                    end else begin
                        nx.swdiv = st.swdiv + 32'h1;
                    end
                end
            end
        end
        // Hours counter and clock are never cleared here
        if (pf_dn && !st.ret) begin
            nx.sf_q    = 1'b0;
            nx.count   = 16'h0;
            nx.tleft   = 32'h0;
            nx.trun    = 1'b0;
            nx.elapsed = 32'h0;
            nx.swdiv   = 32'h0;
        end
        if (v[`LBIS_F_R] || v[`LBIS_F_RAL]) begin
            nx.q_out = 1'b0;
        end else begin
            nx.q_out = nx.sf_q ^ v[`LBIS_F_INV];
        end

        // Basic gates
        nx.xor_q = (st.lg[0] & st.lg[2]) ^ (st.lg[1] & st.lg[3]);
        nx.not_q = !st.lg[4];

        // Analog path
        if (run) begin
            if (SENSOR_VOLTAGE_IN > 12'(`LBIS_AIN_MAX)) begin
                nx.ain = 10'(`LBIS_AIN_MAX);
            end else begin
                nx.ain = SENSOR_VOLTAGE_IN[9:0];
            end
            nx.scaled = scale(st.ain, st.gain, st.offs);
        end

        // APB read data taken in the setup cycle
        case (APB_REQ.paddr)
            `LBIS_A_LOGIC:  rd = {27'h0, st.lg};
            `LBIS_A_SFIN:   rd = {7'h0, st.sfc, 7'h0, st.sfv};
            `LBIS_A_SFCFG:  rd = {st.tval, 10'h0, st.mprot, st.prog, st.prot, st.ret, st.tb};
            `LBIS_A_STAT:   rd = {26'h0, st.bk_exp, st.pf_lvl, st.trun, st.q_out, st.not_q, st.xor_q};
            `LBIS_A_COUNT:  rd = {16'h0, st.count};
            `LBIS_A_ELAP:   rd = st.elapsed;
            `LBIS_A_RTC:    rd = st.rtc;
            `LBIS_A_AIN:    rd = {22'h0, st.ain};
            `LBIS_A_GAIN:   rd = 32'(st.gain);
            `LBIS_A_OFFS:   rd = 32'(st.offs);
            `LBIS_A_SCALED: rd = st.scaled;
            `LBIS_A_MSGG:   rd = 32'(st.gain);
            `LBIS_A_HOURS:  rd = st.hours;
            default:        rd = 32'h0;
        endcase
        if (APB_REQ.psel && !APB_REQ.penable) begin
            nx.prdata = hit ? rd : 32'h0;
        end

        // APB writes at the access edge
        if (acc && APB_REQ.pwrite && hit) begin
            case (APB_REQ.paddr)
                `LBIS_A_LOGIC: nx.lg = APB_REQ.pwdata[4:0];
                `LBIS_A_SFIN: begin
                    nx.sfv = APB_REQ.pwdata[8:0];
                    nx.sfc = APB_REQ.pwdata[`LBIS_F_CONN +: 9];
                end
                `LBIS_A_SFCFG: begin
                    nx.tb    = lbis_tb_e'(APB_REQ.pwdata[1:0]);
                    nx.ret   = APB_REQ.pwdata[`LBIS_F_RET];
                    nx.prot  = APB_REQ.pwdata[`LBIS_F_PROT];
                    nx.prog  = APB_REQ.pwdata[`LBIS_F_PROG];
                    nx.mprot = APB_REQ.pwdata[`LBIS_F_MPROT];
                    if (ed) begin
                        nx.tval = APB_REQ.pwdata[`LBIS_F_TVAL +: 16];
                    end
                end
                `LBIS_A_RTC: begin
                    nx.rtc    = APB_REQ.pwdata;
                    nx.subsec = 7'h0;
                end
                `LBIS_A_GAIN: if (ed) begin
                    nx.gain = 11'(clamp($signed(APB_REQ.pwdata), `LBIS_GAIN_LIM));
                end
                `LBIS_A_OFFS: if (ed) begin
                    nx.offs = 15'(clamp($signed(APB_REQ.pwdata), `LBIS_OFFS_LIM));
                end
                `LBIS_A_MSGG: if (!st.mprot) begin
                    nx.gain = 11'(clamp($signed(APB_REQ.pwdata), `LBIS_GAIN_LIM));
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st      <= '0;
            st.gain <= `LBIS_RST_GAIN;
        end else begin
            st <= nx;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign APB_RSP.prdata  = st.prdata;
    assign APB_RSP.pready  = 1'b1;
    assign APB_RSP.pslverr = acc & !hit;
    assign XOR_Q = st.xor_q;
    assign NOT_Q = st.not_q;
    assign SF_Q  = st.q_out;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    sequence s_lg_wr;
        acc && APB_REQ.pwrite && APB_REQ.paddr == `LBIS_A_LOGIC;
    endsequence

    property p_xor;
        logic [4:0] d;
        (s_lg_wr, d = APB_REQ.pwdata[4:0]) |=> ##1 st.xor_q == ((d[0] & d[2]) ^ (d[1] & d[3]));
    endproperty
    a_xor: assert property (p_xor) else $error("xor output wrong");

    property p_not;
        logic [4:0] d;
        (s_lg_wr, d = APB_REQ.pwdata[4:0]) |=> ##1 st.not_q == !d[4];
    endproperty
    a_not: assert property (p_not) else $error("not output wrong");

    property p_set;
        (v[0] && v[5] && !v[1] && !v[7] && !st.pf_lvl) |=> st.sf_q;
    endproperty
    a_set: assert property (p_set) else $error("set did not force one");

    property p_rst;
        v[1] |=> !st.q_out && !st.trun;
    endproperty
    a_rst: assert property (p_rst) else $error("reset did not clear");

    property p_cnt;
        (v[3] && !st.cnt_d && v[5] && !v[1] && !v[7] && !st.pf_lvl && !v[4])
            |=> st.count == $past(st.count) + 16'h1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count up missed");

    property p_en;
        (!v[5] && !v[1] && !v[7] && !st.pf_lvl) |=> $stable(st.count) && $stable(st.elapsed);
    endproperty
    a_en: assert property (p_en) else $error("disabled block changed");

    property p_inv;
        (!v[1] && !v[7]) |=> st.q_out == (st.sf_q ^ $past(v[6]));
    endproperty
    a_inv: assert property (p_inv) else $error("invert wrong");

    property p_ral;
        (v[7] && !st.pf_lvl) |=> st.count == 16'h0 && st.elapsed == 32'h0 && !st.trun;
    endproperty
    a_ral: assert property (p_ral) else $error("reset all left values");

    property p_ain;
        (!st.pf_lvl && SENSOR_VOLTAGE_IN > 12'(`LBIS_AIN_MAX)) |=> st.ain == 10'(`LBIS_AIN_MAX);
    endproperty
    a_ain: assert property (p_ain) else $error("analog above full scale");

    property p_prot;
        (acc && APB_REQ.pwrite && APB_REQ.paddr == `LBIS_A_GAIN && st.prot && !st.prog)
            |=> $stable(st.gain);
    endproperty
    a_prot: assert property (p_prot) else $error("protected gain changed");
endmodule
`default_nettype wire

// >>> test/lbis_top_tb.sv
/*
 Self-checking bench of lbis_top: gates, special function,
 counter, retention, backup clock, protection, scaling.
 Assumes lbis_map.svh offsets and an APB slave with pready high.
*/
`include "lbis_map.svh"
`default_nettype none
module lbis_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lbis_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int LIMIT = 20000;
    logic          clk_sys;
    logic          srst;
    logic          pwr_fail;
    logic          pps;
    lbis_apb_req_s req;
    lbis_apb_rsp_s rsp;
    logic [11:0]   ain;
    logic          xor_q;
    logic          not_q;
    logic          sf_q;
    logic [33:0]   note_q[$];
    logic [33:0]   n;
    logic          x;
    int            failures;
    int            num_checks;
    int            cyc;
    int            a;
    int            g;
    int            o;
    logic [31:0]   seed = 32'hBDC974C0;
    int            va[6] = '{300, 675, 1500, 2, 2, 333};
    int            vg[6] = '{10, 400, 1000, 1, 1000, -7};
    int            vo[6] = '{-30, 1000, -10000, 0, 0, 0};

    lbis_top #(.TICK_CYC(10), .BKUP_SEC(3)) dut (
        .CLK_SYS(clk_sys), .SRST(srst), .APB_REQ(req), .APB_RSP(rsp),
        .SENSOR_VOLTAGE_IN(ain), .POWER_FAIL(pwr_fail), .REF_PPS(pps),
        .XOR_Q(xor_q), .NOT_Q(not_q), .SF_Q(sf_q));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tk(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // Releases for one idle cycle, so no signal is driven twice per step
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
                        input logic [31:0] e, input logic rc, input logic er);
        note_q.push_back({rc, er, e});
        req <= '{1'b1, 1'b0, w, ad, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (rsp.pready !== 1'b1);
        req <= '0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b0, ad, 32'h0, e, 1'b1, 1'b0);
    endtask

    task automatic sf(input logic [8:0] v, input logic [8:0] c, input logic e);
        wr(`LBIS_A_SFIN, {7'h0, c, 7'h0, v});
        tk(2);
        chk("SF_Q", e, sf_q);
    endtask

    // Count pulse with enable held high
    task automatic pulse(input logic d);
        wr(`LBIS_A_SFIN, {16'h01FF, 7'h0, 4'b0001, d, 4'h8});
        wr(`LBIS_A_SFIN, {16'h01FF, 7'h0, 4'b0001, d, 4'h0});
    endtask

    task automatic pwr(input int k);
        pwr_fail <= 1'b1;
        tk(k);
        pwr_fail <= 1'b0;
        tk(20);
    endtask
    // ----------------------------------------
    // Monitor and timeout
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            n = note_q.pop_front();
            chk("pslverr", n[32], rsp.pslverr);
            if (n[33]) begin
                chk("prdata", n[31:0], rsp.prdata);
            end
        end
        if (cyc == LIMIT) begin
            failures++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        req = '0;
        srst = 1'b1;
        ain = '0;
        pwr_fail = 1'b0;
        pps = 1'b0;
        failures = 0;
        num_checks = 0;
        cyc = 0;
        tk(8);
        srst <= 1'b0;
        tk(1);
        rd(`LBIS_A_GAIN, 32'h64);
        rd(`LBIS_A_STAT, 32'h2);
        xfer(1'b0, 8'h34, 32'h0, 32'h0, 1'b1, 1'b1);
        xfer(1'b1, 8'h05, 32'h1, 32'h0, 1'b0, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            wr(`LBIS_A_LOGIC, i);
            tk(2);
            x = (i[0] & i[2]) ^ (i[1] & i[3]);
            chk("XOR_Q", x, xor_q);
            chk("NOT_Q", !i[4], not_q);
            rd(`LBIS_A_STAT, {30'h0, !i[4], x});
        end
        $display("test gates done");
        // First six fixed corners, then random
        for (int k = 0; k < 10; k++) begin
            a = k < 6 ? va[k] : rnd() % 4096;
            g = k < 6 ? vg[k] : int'(rnd() % 2001) - 1000;
            o = k < 6 ? vo[k] : int'(rnd() % 20001) - 10000;
            ain <= a[11:0];
            wr(`LBIS_A_GAIN, g);
            wr(`LBIS_A_OFFS, o);
            tk(3);
            a = a > 1000 ? 1000 : a;
            rd(`LBIS_A_AIN, a);
            rd(`LBIS_A_SCALED, a * g / 100 + o);
        end
        wr(`LBIS_A_GAIN, 32'h7D0);
        rd(`LBIS_A_GAIN, 32'h3E8);
        wr(`LBIS_A_OFFS, 32'h4E20);
        rd(`LBIS_A_OFFS, 32'h2710);
        $display("test analog done");
        wr(`LBIS_A_SFCFG, 32'h8);
        wr(`LBIS_A_GAIN, 32'h5);
        rd(`LBIS_A_GAIN, 32'h3E8);
        wr(`LBIS_A_MSGG, 32'h7);
        rd(`LBIS_A_GAIN, 32'h7);
        wr(`LBIS_A_SFCFG, 32'h28);
        wr(`LBIS_A_MSGG, 32'h9);
        rd(`LBIS_A_GAIN, 32'h7);
        wr(`LBIS_A_SFCFG, 32'h18);
        wr(`LBIS_A_GAIN, 32'h5);
        rd(`LBIS_A_GAIN, 32'h5);
        $display("test protect done");
        wr(`LBIS_A_SFCFG, 32'h0);
        sf(9'h001, 9'h1FF, 1'b0);
        sf(9'h021, 9'h1FF, 1'b1);
        sf(9'h023, 9'h1FF, 1'b0);
        sf(9'h021, 9'h1FE, 1'b0);
        sf(9'h060, 9'h1FF, 1'b1);
        sf(9'h020, 9'h1FF, 1'b0);
        wr(`LBIS_A_SFCFG, 32'h0005_0000);
        wr(`LBIS_A_SFIN, 32'h01FF_0024);
        tk(20);
        chk("SF_Q", 1'b0, sf_q);
        tk(70);
        chk("SF_Q", 1'b1, sf_q);
        $display("test special done");
        wr(`LBIS_A_SFIN, 32'h01FF_00A0);
        wr(`LBIS_A_SFCFG, 32'h4);
        repeat (3) pulse(1'b0);
        pulse(1'b1);
        tk(2);
        rd(`LBIS_A_COUNT, 32'h2);
        pwr(20);
        rd(`LBIS_A_COUNT, 32'h2);
        wr(`LBIS_A_SFCFG, 32'h0);
        pwr(20);
        rd(`LBIS_A_COUNT, 32'h0);
        repeat (2) pulse(1'b0);
        wr(`LBIS_A_SFIN, 32'h01FF_00A0);
        tk(2);
        rd(`LBIS_A_COUNT, 32'h0);
        $display("test counter done");
        // Outage well past three clock seconds
        wr(`LBIS_A_RTC, 32'h64);
        pwr(4500);
        rd(`LBIS_A_RTC, 32'h64);
        $display("test backup done");
        // Late reference edge adds a second, early one only re-aligns
        wr(`LBIS_A_RTC, 32'h10);
        tk(600);
        pps <= 1'b1;
        tk(8);
        pps <= 1'b0;
        tk(8);
        rd(`LBIS_A_RTC, 32'h11);
        tk(200);
        pps <= 1'b1;
        tk(8);
        pps <= 1'b0;
        tk(8);
        rd(`LBIS_A_RTC, 32'h11);
        // Without re-alignment the next second would already be in
        tk(900);
        rd(`LBIS_A_RTC, 32'h11);
        $display("test reference done");
        wr(`LBIS_A_SFCFG, 32'h3);
        wr(`LBIS_A_SFIN, 32'h01FF_0120);
        tk(50);
        rd(`LBIS_A_ELAP, 32'h0);
        $display("test pause done");
        tk(3);
        if (note_q.size() != 0) begin
            failures++;
        end
        wrap_up();
    end
endmodule
`default_nettype wire
